/* hw/mbus_pkg.sv */
// Constants, types and helpers shared by the Modbus RTU sensor slave
package mbus_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned BAUD_0   = 4800;
  localparam int unsigned BAUD_1   = 9600;
  localparam int unsigned BAUD_2   = 19200;
  localparam int unsigned BAUD_3   = 38400;
  localparam logic [2:0]  GAP_BITS = 3'h4;
  localparam logic [4:0]  MAX_BYTES = 5'h18;   // 1+1+20+2
  // ------------------------------------------------------------
  // protocol codes and limits
  // ------------------------------------------------------------
  localparam logic [7:0]  FC_READ  = 8'h03;
  localparam logic [7:0]  FC_WR1   = 8'h06;
  localparam logic [7:0]  FC_WRN   = 8'h10;
  localparam logic [7:0]  EXC_FLAG = 8'h80;
  localparam logic [7:0]  EX_FUNC  = 8'h01;
  localparam logic [7:0]  EX_ADDR  = 8'h02;
  localparam logic [7:0]  EX_VAL   = 8'h03;
  localparam logic [15:0] RD_MAX   = 16'h0008;
  localparam logic [15:0] WR_MAX   = 16'h0007;  // 5 header + 14 value bytes fit 20
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] KEY      = 16'hAA55;
  // ------------------------------------------------------------
  // register map, reset values and value limits
  // ------------------------------------------------------------
  localparam logic [15:0] REG_SER_FIRST = 16'h0030;
  localparam logic [15:0] REG_SER_LAST  = 16'h0035;
  localparam logic [15:0] REG_FLOW_HI   = 16'h003A;
  localparam logic [15:0] REG_FLOW_LO   = 16'h003B;
  localparam logic [15:0] REG_NODE      = 16'h0081;
  localparam logic [15:0] REG_SPEED     = 16'h0082;
  localparam logic [15:0] REG_GAS       = 16'h008B;
  localparam logic [15:0] REG_DEPTH     = 16'h008C;
  localparam logic [15:0] REG_CAL       = 16'h00F0;
  localparam logic [15:0] REG_UNLOCK    = 16'h00FF;
  localparam logic [15:0] NODE_RST      = 16'h0001;
  localparam logic [15:0] SPEED_RST     = 16'h0003;
  localparam logic [15:0] GAS_RST       = 16'h03E8;
  localparam logic [15:0] DEPTH_RST     = 16'h0003;
  localparam logic [15:0] NODE_MAX      = 16'h00F7;
  localparam logic [15:0] NODE_HOLE     = 16'h009D;
  localparam logic [15:0] SPEED_MAX     = 16'h0003;
  localparam logic [15:0] DEPTH_MAX     = 16'h0009;

  // gray along receive -> check -> write -> transmit
  typedef enum logic [1:0] {
    ST_RX  = 2'h0,
    ST_CHK = 2'h1,
    ST_WR  = 2'h3,
    ST_TX  = 2'h2
  } state_t;

  // one byte through the reflected CRC-16
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

/* hw/modbus_rtu_sensor_slave.sv */
// Modbus RTU slave: framing, register map and response transmitter
`timescale 1ns/10ps
module modbus_rtu_sensor_slave #(
  parameter int unsigned SYS_HZ = mbus_pkg::CLK_HZ  // lower in simulation to shorten bit times
) (
  input  wire logic        clk_sys,      // core clock
  input  wire logic        reset_n,      // async reset, active low
  input  wire logic        rx_pin,       // line receive data
  output logic             tx_pin,       // line transmit data
  output logic             tx_drive,     // transceiver driver enable
  input  wire logic [31:0] flow_value,   // flow in ml/min
  input  wire logic [95:0] serial_text,  // ASCII, first char in top byte
  output logic [15:0]      gas_factor,   // gas correction factor
  output logic [15:0]      avg_depth,    // averaging depth exponent
  output logic             cal_start     // zero calibration start pulse
);
  import mbus_pkg::*;

  state_t      state_q;
  logic        rx_s1_q, rx_s2_q, rx_busy_q, byte_v_q;
  logic        gap_q, armed_q, ovf_q;
  logic        unlock_q, prot_wr_q, cal_q, tx_busy_q;
  logic [1:0]  speed_act_q;
  logic [2:0]  idle_bits_q;
  logic [3:0]  rx_bit_q, idx_q, tx_bit_q;
  logic [4:0]  nbytes_q, tx_idx_q;
  logic [7:0]  rx_sh_q, exc_q;
  logic [7:0]  frm_q [0:23];
  logic [9:0]  tx_sh_q;
  logic [15:0] rx_cnt_q, idle_cnt_q, crc_q, tx_cnt_q, tx_crc_q;
  logic [15:0] node_q, speed_q, gas_q, depth_q, node_act_q;
  logic [31:0] flow_q;

  // ------------------------------------------------------------
  // request field decode
  // ------------------------------------------------------------
  wire [15:0] div     = (speed_act_q == 2'h0) ? 16'(SYS_HZ / BAUD_0)
                      : (speed_act_q == 2'h1) ? 16'(SYS_HZ / BAUD_1)
                      : (speed_act_q == 2'h2) ? 16'(SYS_HZ / BAUD_2) : 16'(SYS_HZ / BAUD_3);
  wire [7:0]  fc      = frm_q[1];
  wire [15:0] start_a = {frm_q[2], frm_q[3]};
  wire [15:0] qty     = {frm_q[4], frm_q[5]};
  wire [7:0]  bcnt    = frm_q[6];
  wire        is_rd   = fc == FC_READ;
  wire        is_w1   = fc == FC_WR1;
  wire        is_wn   = fc == FC_WRN;
  wire [3:0]  n_regs  = is_w1 ? 4'h1 : qty[3:0];
  wire [3:0]  last    = 4'(n_regs - 4'h1);
  wire [7:0]  nb8     = {3'h0, nbytes_q};
  wire        len_ok  = is_rd ? (nb8 == 8'h08 && qty != 16'h0000 && qty <= RD_MAX)
                      : is_w1 ? nb8 == 8'h08
                      : (qty != 16'h0000 && qty <= WR_MAX && bcnt == {qty[6:0], 1'b0}
                         && nb8 == 8'(bcnt + 8'h09));
  wire [7:0]  pre_code = !(is_rd | is_w1 | is_wn) ? EX_FUNC : !len_ok ? EX_VAL : 8'h00;
  // frame end: gap after bytes; good residue is zero over data plus CRC
  wire        eof      = gap_q && state_q == ST_RX && nbytes_q != 5'h00;
  wire        frame_ok = !ovf_q && nbytes_q >= 5'h04 && crc_q == 16'h0000
                         && frm_q[0] == node_act_q[7:0];

  // ------------------------------------------------------------
  // register addressing shared by check, write and reply
  // ------------------------------------------------------------
  wire [4:0]  rk      = 5'(tx_idx_q - 5'h03);
  wire [3:0]  roff    = (state_q == ST_TX) ? rk[4:1] : idx_q;
  wire [15:0] ra      = 16'(start_a + {12'h000, roff});
  wire [4:0]  wptr    = is_w1 ? 5'h04 : 5'(5'h07 + {idx_q, 1'b0});
  wire [15:0] wval    = {frm_q[wptr], frm_q[5'(wptr + 5'h01)]};
  wire        sel_ser = ra >= REG_SER_FIRST && ra <= REG_SER_LAST;
  wire        sel_flh = ra == REG_FLOW_HI;
  wire        sel_fll = ra == REG_FLOW_LO;
  wire        sel_nod = ra == REG_NODE;
  wire        sel_spd = ra == REG_SPEED;
  wire        sel_gas = ra == REG_GAS;
  wire        sel_dep = ra == REG_DEPTH;
  wire        sel_cal = ra == REG_CAL;
  wire        sel_unl = ra == REG_UNLOCK;
  wire [2:0]  ser_i   = 3'(3'h5 - ra[2:0]);
  // write-only registers are not readable
  wire        readable = sel_ser | sel_flh | sel_fll | sel_nod | sel_spd | sel_gas | sel_dep;
  wire [15:0] rd_val  = sel_ser ? serial_text[16*ser_i +: 16]
                      : sel_flh ? flow_q[31:16] : sel_fll ? flow_q[15:0]
                      : sel_nod ? node_q : sel_spd ? speed_q
                      : sel_gas ? gas_q : sel_dep ? depth_q : 16'h0000;
  // legality of one write; protected targets refuse while locked
  wire        node_ok = wval != 16'h0000 && wval <= NODE_MAX && wval != NODE_HOLE;
  wire [7:0]  wr_code = sel_nod ? (node_ok ? 8'h00 : EX_VAL)
                      : sel_spd ? (wval <= SPEED_MAX ? 8'h00 : EX_VAL)
                      : sel_gas ? (unlock_q ? 8'h00 : EX_ADDR)
                      : sel_dep ? (!unlock_q ? EX_ADDR : wval <= DEPTH_MAX ? 8'h00 : EX_VAL)
                      : sel_cal ? (!unlock_q ? EX_ADDR : wval == KEY ? 8'h00 : EX_VAL)
                      : sel_unl ? 8'h00 : EX_ADDR;
  wire [7:0]  chk_code = is_rd ? (readable ? 8'h00 : EX_ADDR) : wr_code;
  wire        wr_prot  = sel_gas | sel_dep | sel_cal;
  wire        wr_last  = state_q == ST_WR && idx_q == last;

  // ------------------------------------------------------------
  // reply assembly
  // ------------------------------------------------------------
  wire        exc_on  = exc_q != 8'h00;
  wire [4:0]  tx_len  = exc_on ? 5'h05 : is_rd ? 5'(5'h05 + {n_regs, 1'b0}) : 5'h08;
  wire [4:0]  dat_len = 5'(tx_len - 5'h02);
  wire [7:0]  body    = (tx_idx_q == 5'h00) ? frm_q[0]
                      : (tx_idx_q == 5'h01) ? (exc_on ? (fc | EXC_FLAG) : fc)
                      : exc_on ? exc_q
                      : !is_rd ? frm_q[tx_idx_q]
                      : (tx_idx_q == 5'h02) ? {3'h0, n_regs, 1'b0}
                      : rk[0] ? rd_val[7:0] : rd_val[15:8];
  // check value goes out low byte first
  wire [7:0]  tx_byte = (tx_idx_q == dat_len) ? tx_crc_q[7:0]
                      : (tx_idx_q > dat_len) ? tx_crc_q[15:8] : body;

  assign tx_pin     = tx_sh_q[0];
  assign tx_drive   = state_q == ST_TX;
  assign gas_factor = gas_q;
  assign avg_depth  = depth_q;
  assign cal_start  = cal_q;

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------
  // two-stage synchroniser on the line pin
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // 8N1 character receiver sampling mid-bit; a start glitch aborts
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      byte_v_q  <= 1'b0;
    end else begin
      byte_v_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s2_q && state_q == ST_RX) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= {1'b0, div[15:1]};
          rx_bit_q  <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= 16'(rx_cnt_q - 16'h0001);
      end else begin
        rx_cnt_q <= 16'(div - 16'h0001);
        rx_bit_q <= 4'(rx_bit_q + 4'h1);
        if (rx_bit_q == 4'h0 && rx_s2_q) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          byte_v_q  <= rx_s2_q;
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
        end
      end
    end
  end

  // idle timer; also held off while we drive, so our reply is followed by a gap
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_q  <= 16'h0000;
      idle_bits_q <= 3'h0;
      gap_q       <= 1'b0;
    end else begin
      gap_q <= 1'b0;
      if (rx_busy_q || !rx_s2_q || state_q == ST_TX) begin
        idle_cnt_q  <= 16'h0000;
        idle_bits_q <= 3'h0;
      end else if (idle_bits_q != GAP_BITS) begin
        if (idle_cnt_q == 16'(div - 16'h0001)) begin
          idle_cnt_q  <= 16'h0000;
          idle_bits_q <= 3'(idle_bits_q + 3'h1);
          gap_q       <= idle_bits_q == 3'(GAP_BITS - 3'h1);
        end else begin
          idle_cnt_q <= 16'(idle_cnt_q + 16'h0001);
        end
      end
    end
  end

  // frame collection; characters count only after a gap has opened the frame
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      armed_q  <= 1'b0;
      ovf_q    <= 1'b0;
      nbytes_q <= 5'h00;
      crc_q    <= CRC_INIT;
      for (int i = 0; i < 24; i++) frm_q[i] <= 8'h00;
    end else if (gap_q) begin
      armed_q  <= !(eof && frame_ok);
      ovf_q    <= 1'b0;
      nbytes_q <= 5'h00;
      crc_q    <= CRC_INIT;
    end else if (state_q != ST_RX) begin
      armed_q <= 1'b0;
    end else if (byte_v_q && armed_q) begin
      if (nbytes_q < MAX_BYTES) begin
        frm_q[nbytes_q] <= rx_sh_q;
        nbytes_q        <= 5'(nbytes_q + 5'h01);
        crc_q           <= crc_byte(crc_q, rx_sh_q);
      end else begin
        ovf_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer: check every target first, then write, then reply
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RX;
      exc_q   <= 8'h00;
      idx_q   <= 4'h0;
      flow_q  <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_RX: begin
          if (eof && frame_ok) begin
            state_q <= ST_CHK;
            exc_q   <= pre_code;
            idx_q   <= 4'h0;
            flow_q  <= flow_value;  // both halves from one sample
          end
        end
        ST_CHK: begin
          if (exc_on) begin
            state_q <= ST_TX;
          end else if (chk_code != 8'h00) begin
            exc_q   <= chk_code;
            state_q <= ST_TX;
          end else if (idx_q == last) begin
            idx_q   <= 4'h0;
            state_q <= is_rd ? ST_TX : ST_WR;
          end else begin
            idx_q <= 4'(idx_q + 4'h1);
          end
        end
        ST_WR: begin
          if (idx_q == last) begin
            state_q <= ST_TX;
          end else begin
            idx_q <= 4'(idx_q + 4'h1);
          end
        end
        ST_TX: begin
          if (!tx_busy_q && tx_idx_q == tx_len) state_q <= ST_RX;
        end
        default: state_q <= ST_RX;
      endcase
    end
  end

  // register writes; only reached once all targets passed the check
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      node_q    <= NODE_RST;
      speed_q   <= SPEED_RST;
      gas_q     <= GAS_RST;
      depth_q   <= DEPTH_RST;
      unlock_q  <= 1'b0;
      prot_wr_q <= 1'b0;
      cal_q     <= 1'b0;
    end else begin
      cal_q <= 1'b0;
      if (state_q == ST_CHK) prot_wr_q <= 1'b0;
      if (state_q == ST_WR) begin
        if (sel_nod) node_q <= wval;
        if (sel_spd) speed_q <= wval;
        if (sel_gas) gas_q <= wval;
        if (sel_dep) depth_q <= wval;
        if (sel_cal) cal_q <= 1'b1;
        if (sel_unl) unlock_q <= wval == KEY;
        if (wr_prot) prot_wr_q <= 1'b1;
        // relock at the end of the frame that changed a protected value
        if (wr_last && (prot_wr_q || wr_prot)) unlock_q <= 1'b0;
      end
    end
  end

  // settings in use follow the stored ones only between transactions
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      node_act_q  <= NODE_RST;
      speed_act_q <= SPEED_RST[1:0];
    end else if (state_q == ST_RX) begin
      node_act_q  <= node_q;
      speed_act_q <= speed_q[1:0];
    end
  end

  // ------------------------------------------------------------
  // transmit path
  // ------------------------------------------------------------
  // reply serialiser: start, 8 data lsb first, stop; crc over body bytes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3FF;
      tx_idx_q  <= 5'h00;
      tx_crc_q  <= CRC_INIT;
    end else if (state_q != ST_TX) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 10'h3FF;
      tx_idx_q  <= 5'h00;
      tx_crc_q  <= CRC_INIT;
    end else if (!tx_busy_q) begin
      if (tx_idx_q != tx_len) begin
        tx_sh_q   <= {1'b1, tx_byte, 1'b0};
        tx_busy_q <= 1'b1;
        tx_cnt_q  <= 16'(div - 16'h0001);
        tx_bit_q  <= 4'h0;
        tx_idx_q  <= 5'(tx_idx_q + 5'h01);
        if (tx_idx_q < dat_len) tx_crc_q <= crc_byte(tx_crc_q, tx_byte);
      end
    end else if (tx_cnt_q != 16'h0000) begin
      tx_cnt_q <= 16'(tx_cnt_q - 16'h0001);
    end else begin
      tx_cnt_q <= 16'(div - 16'h0001);
      tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
      tx_bit_q <= 4'(tx_bit_q + 4'h1);
      if (tx_bit_q == 4'h9) tx_busy_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_QUIET_UNLESS_ASKED: assert property (!tx_drive |-> tx_pin)
    else $error("line driven low outside a reply");
  AST_NO_BROADCAST: assert property (eof && frm_q[0] == 8'h00 |=> state_q == ST_RX)
    else $error("broadcast frame was acted on");
  AST_BAD_CRC_DROP: assert property (eof && crc_q != 16'h0000 |=> state_q == ST_RX)
    else $error("frame with bad check value accepted");
  AST_NODE_RANGE: assert property (node_q != 16'h0000 && node_q <= NODE_MAX && node_q != NODE_HOLE)
    else $error("node address out of range");
  AST_SPEED_RANGE: assert property (speed_q <= SPEED_MAX)
    else $error("speed code out of range");
  AST_DEPTH_RANGE: assert property (depth_q <= DEPTH_MAX)
    else $error("averaging depth out of range");
  AST_RELOCK: assert property (wr_last && (prot_wr_q || wr_prot) |=> !unlock_q [*2])
    else $error("protection not re-armed after protected write");
  AST_SETTINGS_HELD: assert property (state_q != ST_RX |=> $stable(node_act_q) && $stable(speed_act_q))
    else $error("active settings changed during a transaction");
  AST_CAL_KEY: assert property (cal_start |-> $past(wval) == KEY && $past(unlock_q))
    else $error("calibration started without key");
  AST_EXC_NO_WRITE: assert property (state_q == ST_CHK && chk_code != 8'h00 |=> state_q == ST_TX)
    else $error("refused request reached the write stage");

  COV_READ_REPLY: cover property (state_q == ST_CHK && is_rd ##1 state_q == ST_TX && !exc_on);
  COV_WRITE: cover property (state_q == ST_WR ##1 state_q == ST_TX);
  COV_EXCEPTION: cover property (state_q == ST_TX && exc_on);
endmodule

/* dv/mb_master.sv */
// Modbus master model on the slave's half-duplex line
`timescale 1ns/10ps
module mb_master #(
  parameter int BT = 10  // clocks per bit time
) (
  input  wire logic clk_sys,  // core clock
  output logic      rx_line,  // drives slave receive pin
  input  wire logic tx_pin,   // slave transmit data
  input  wire logic tx_drive  // slave driver enable
);
  // reflected crc, residue 0 over a frame with its crc
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // bit time in use; the bench moves it when the slave changes line speed
  int bt = BT;
  initial rx_line = 1'b1;
  task automatic put_bit(input logic b);
    rx_line = b;
    repeat (bt) @(negedge clk_sys);
  endtask
  // idle gap first so the slave sees a frame start; master only, one request at a time
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    repeat (6 * bt) @(negedge clk_sys);
    foreach (q[i]) begin
      put_bit(1'b0);
      for (int b = 0; b < 8; b++) put_bit(q[i][b]);
      put_bit(1'b1);
    end
  endtask
  // sample mid-bit while the slave holds its driver on
  task automatic recv(output logic [7:0] q[$], output logic ok);
    logic [7:0] v;
    int n;
    q = {};
    n = 0;
    while (tx_drive !== 1'b1 && n < 40 * bt) begin
      @(negedge clk_sys);
      n++;
    end
    while (tx_drive === 1'b1) begin
      if (tx_pin === 1'b0) begin
        repeat (bt / 2) @(negedge clk_sys);
        for (int b = 0; b < 8; b++) begin
          repeat (bt) @(negedge clk_sys);
          v[b] = tx_pin;
        end
        repeat (bt) @(negedge clk_sys);
        q.push_back(v);
      end else @(negedge clk_sys);
    end
    ok = q.size() > 2 && crc16(q) == 16'h0000;
  endtask
endmodule

/* dv/modbus_rtu_sensor_slave_test.sv */
// Self-checking bench for the Modbus RTU sensor slave
`timescale 1ns/10ps
module modbus_rtu_sensor_slave_test;
  import mbus_pkg::*;
  logic        clk_sys, reset_n, rx_pin, tx_pin, tx_drive, cal_start, cal_seen;
  logic [31:0] flow_value;
  logic [95:0] serial_text;
  logic [15:0] gas_factor, avg_depth;
  logic [7:0]  nd, none[$];
  int          fail_count, cmp_count;
  // 384 kHz core in sim gives ten clocks per bit at 38400
  modbus_rtu_sensor_slave #(.SYS_HZ(384000)) u_modbus_rtu_sensor_slave (.clk_sys, .reset_n, .rx_pin, .tx_pin,
    .tx_drive, .flow_value, .serial_text, .gas_factor, .avg_depth, .cal_start);
  mb_master #(.BT(10)) u_mb_master (.clk_sys, .rx_line(rx_pin), .tx_pin, .tx_drive);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // the pulse lasts one clock, so latch it
  always @(posedge clk_sys) if (cal_start === 1'b1) cal_seen <= 1'b1;
  // ------------------------------------------------------------
  // check and transfer tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xact(input logic [7:0] rq[$], input logic [7:0] ex[$], input logic bad);
    logic [7:0] rp[$];
    logic       ok;
    u_mb_master.send(rq, bad);
    u_mb_master.recv(rp, ok);
    check(rp.size(), ex.size() + (ex.size() ? 2 : 0));
    if (ex.size()) check(ok, 32'h1);
    foreach (ex[i]) if (i < rp.size()) check(rp[i], ex[i]);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] n, input logic [7:0] ex[$]);
    xact({nd, 8'h03, a[15:8], a[7:0], n[15:8], n[7:0]}, ex, 1'b0);
  endtask
  // an empty expectation means a plain echo
  task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic [7:0] ex[$]);
    logic [7:0] q[$];
    q = {nd, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]};
    if (ex.size() == 0) ex = q[0:5];
    xact(q, ex, 1'b0);
  endtask
  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, fail_count);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] ex[$];
    reset_n = 1'b0;
    cal_seen = 1'b0;
    nd = 8'h01;
    flow_value = 32'h0001_4F74;
    serial_text = "A1B23456CDEF";
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    rd(16'h0081, 16'h0002, {nd, 8'h03, 8'h04, 8'h00, 8'h01, 8'h00, 8'h03});
    rd(16'h008B, 16'h0002, {nd, 8'h03, 8'h04, 8'h03, 8'hE8, 8'h00, 8'h03});
    rd(16'h003A, 16'h0002, {nd, 8'h03, 8'h04, 8'h00, 8'h01, 8'h4F, 8'h74});
    ex = {nd, 8'h03, 8'h0C};
    for (int i = 11; i >= 0; i--) ex.push_back(serial_text[i*8+:8]);
    rd(16'h0030, 16'h0006, ex);
    done("reads");
    wr(16'h0030, 16'h1111, {nd, 8'h86, 8'h02});
    wr(16'h008B, 16'h1234, {nd, 8'h86, 8'h02});
    wr(16'h00FF, 16'hAA55, none);
    wr(16'h008B, 16'h1234, none);
    check(gas_factor, 32'h1234);
    wr(16'h008B, 16'h4321, {nd, 8'h86, 8'h02});
    check(gas_factor, 32'h1234);
    wr(16'h00FF, 16'hAA55, none);
    xact({nd, 8'h10, 8'h00, 8'h8C, 8'h00, 8'h01, 8'h02, 8'h00, 8'h05},
         {nd, 8'h10, 8'h00, 8'h8C, 8'h00, 8'h01}, 1'b0);
    check(avg_depth, 32'h5);
    check(cal_seen, 32'h0);
    wr(16'h00FF, 16'hAA55, none);
    wr(16'h00F0, 16'hAA55, none);
    check(cal_seen, 32'h1);
    done("protection");
    rd(16'h00F0, 16'h0001, {nd, 8'h83, 8'h02});
    xact({nd, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, {nd, 8'h84, 8'h01}, 1'b0);
    xact({nd, 8'h03, 8'h00, 8'h81, 8'h00, 8'h01}, none, 1'b1);
    xact({8'h02, 8'h03, 8'h00, 8'h81, 8'h00, 8'h01}, none, 1'b0);
    xact({8'h00, 8'h06, 8'h00, 8'h8C, 8'h00, 8'h02}, none, 1'b0);
    done("errors");
    wr(16'h0081, 16'h009D, {nd, 8'h86, 8'h03});
    wr(16'h0081, 16'h0005, none);
    nd = 8'h05;
    rd(16'h0081, 16'h0001, {nd, 8'h03, 8'h02, 8'h00, 8'h05});
    done("node address");
    // value limits, refused writes keep the unlock, then a slower line
    rd(16'h0081, 16'h0009, {nd, 8'h83, 8'h03});
    xact({nd, 8'h10, 8'h00, 8'h8C, 8'h00, 8'h01, 8'h04, 8'h00, 8'h05}, {nd, 8'h90, 8'h03}, 1'b0);
    wr(16'h00FF, 16'hAA55, none);
    wr(16'h008C, 16'h000A, {nd, 8'h86, 8'h03});
    cal_seen = 1'b0;
    wr(16'h00F0, 16'h1234, {nd, 8'h86, 8'h03});
    check(cal_seen, 32'h0);
    check(avg_depth, 32'h5);
    wr(16'h0082, 16'h0004, {nd, 8'h86, 8'h03});
    wr(16'h0082, 16'h0002, none);
    u_mb_master.bt = 20;
    rd(16'h0082, 16'h0001, {nd, 8'h03, 8'h02, 8'h00, 8'h02});
    done("limits and line speed");
    // reset in mid-run brings back address, speed, depth and protection
    reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    u_mb_master.bt = 10;
    nd = 8'h01;
    rd(16'h0081, 16'h0002, {nd, 8'h03, 8'h04, 8'h00, 8'h01, 8'h00, 8'h03});
    check(avg_depth, 32'h3);
    wr(16'h008B, 16'h0001, {nd, 8'h86, 8'h02});
    done("reset in mid-run");
    end_of_test();
  end
endmodule
